// File: verilog/fpc_front_panel.sv
// fpc_front_panel: commit key interpreter, indicator lamps and register file
// assumes keys and jumper are raw pins, relay and self-test inputs are core_clk logic
//
// Behaviour
// - in setpoint mode commit writes the pending setting into the store at once
// - a stored setting raises a transient saved message
// - actual mode, page 2 prompt at YES, commit erases the peak temperature
// - erasing the peak raises a transient cleared message
// - actual mode, page 4 prompt at YES, commit clears statistics with message
// - commit does nothing outside those three cases
// - commit is ignored unless the access jumper is shorted
// - trip lamp follows the trip relay
// - alarm lamp follows the alarm relay
// - first auxiliary lamp follows the first auxiliary relay
// - second auxiliary lamp follows the second auxiliary relay
// - self-test failure flashes the service lamp
// - low supply lights the service lamp steadily; brief light at power-up
// - in setpoint mode raise and lower change only the pending value until commit
// - in actual mode, on a yes/no prompt raise or lower toggles the answer
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fpc_front_panel
   import fpc_pkg::*;
#(
   parameter int unsigned FLASH_CYCLES = FLASH_CYC,
   parameter int unsigned SVC_HALF_CYCLES = SVC_HALF_CYC,
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int unsigned POWERUP_CYCLES = POWERUP_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // panel pins
   input wire fpc_pkg::fpc_keys_t key_pin,
   input wire logic access_shorted,
   // relay states and health
   input wire fpc_pkg::fpc_relays_t relays,
   input wire logic selftest_fail,
   input wire logic supply_low,
   // measurement records
   input wire logic temp_valid,
   input wire logic [15:0] temp_sample,
   input wire logic motor_start,
   // settings read port for the protection logic
   input wire logic [fpc_pkg::SET_AW-1:0] set_rd_idx,
   output logic [fpc_pkg::SET_DW-1:0] set_rd_val,
   // panel outputs
   output fpc_pkg::fpc_lamps_t lamps,
   output fpc_pkg::fpc_msg_t flash_msg,
   output logic peak_clr,
   output logic stats_clr
);
   import fpc_pkg::*;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] sel);
      merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // input conditioning
   logic [3:0] pin_level, pin_rise;
   fpc_in_filter #(.W(4), .CNT(DEBOUNCE_CYCLES)) u_filter (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .raw({key_pin.commit, key_pin.raise, key_pin.lower, access_shorted}),
      .level(pin_level),
      .rise(pin_rise)
   );
   logic commit_edge, raise_edge, lower_edge, access_ok;
   assign commit_edge = pin_rise[3];
   assign raise_edge = pin_rise[2];
   assign lower_edge = pin_rise[1];
   assign access_ok = pin_level[0];

   ////////////////////////////////////////////////////////////////////
   // register bus
   logic ack_q;
   logic [31:0] dat_q;
   logic req, wr_en;
   logic [5:0] ctrl_q;
   logic [SET_AW-1:0] sel_q;
   logic [15:0] pend_q, peak_q, stats_q;
   logic [SET_DW-1:0] active_val;
   logic answer_q;
   fpc_msg_t msg_q;
   fpc_mode_t mode;
   logic [2:0] page;
   logic prompt;

   assign req = wb_cyc_i & wb_stb_i;
   // writes land on the edge where the master sees ack
   assign wr_en = req & wb_we_i & ack_q;
   assign mode = fpc_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
   assign page = ctrl_q[CTRL_PAGE_LSB +: 3];
   assign prompt = ctrl_q[CTRL_PROMPT_BIT];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dat_q <= 32'h0000_0000;
      end else if (req & ~ack_q) begin
         unique case (wb_adr_i)
            ADR_CTRL: dat_q <= {26'h000_0000, ctrl_q};
            ADR_SEL: dat_q <= {28'h000_0000, sel_q};
            ADR_PEND: dat_q <= {16'h0000, pend_q};
            ADR_ACTIVE: dat_q <= {16'h0000, active_val};
            ADR_STATUS: dat_q <= {27'h000_0000, pin_level[3], msg_q, answer_q, access_ok};
            ADR_PEAK: dat_q <= {16'h0000, peak_q};
            ADR_STATS: dat_q <= {16'h0000, stats_q};
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_en && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
         ctrl_q <= wb_dat_i[5:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sel_q <= '0;
      end else if (wr_en && wb_adr_i == ADR_SEL && wb_sel_i[0]) begin
         sel_q <= wb_dat_i[SET_AW-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // commit decode
   logic do_store, do_peak, do_stats, yes_prompt;
   assign yes_prompt = mode == FPC_MODE_ACTUAL && prompt && answer_q;
   // jumper gates every action; any other mode or page is a no-op
   assign do_store = commit_edge && access_ok && mode == FPC_MODE_SETPOINT;
   assign do_peak = commit_edge && access_ok && yes_prompt && page == PAGE_CLR_PEAK;
   assign do_stats = commit_edge && access_ok && yes_prompt && page == PAGE_COMMISSION;

   // pending value: keys move it, software loads it; the store only sees it on commit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pend_q <= PEND_RST;
      end else if (wr_en && wb_adr_i == ADR_PEND) begin
         pend_q <= merge16(pend_q, wb_dat_i, wb_sel_i);
      end else if (mode == FPC_MODE_SETPOINT && raise_edge && pend_q != PEND_MAX) begin
         pend_q <= pend_q + 16'h0001;
      end else if (mode == FPC_MODE_SETPOINT && lower_edge && pend_q != PEND_RST) begin
         pend_q <= pend_q - 16'h0001;
      end
   end

   // yes/no answer: back to NO whenever the display changes or an action runs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         answer_q <= 1'b0;
      end else if (wr_en && wb_adr_i == ADR_CTRL) begin
         answer_q <= 1'b0;
      end else if (do_peak || do_stats) begin
         answer_q <= 1'b0;
      end else if (mode == FPC_MODE_ACTUAL && prompt && (raise_edge || lower_edge)) begin
         answer_q <= ~answer_q;
      end
   end

   // which store entries hold a defined value; the store itself has no reset
   logic [(1<<SET_AW)-1:0] written_q;
   logic act_ok_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         written_q <= '0;
         act_ok_q <= 1'b0;
      end else begin
         if (do_store) begin
            written_q[sel_q] <= 1'b1;
         end
         act_ok_q <= written_q[sel_q];
      end
   end

   fpc_set_mem u_mem (
      .core_clk(core_clk),
      .we(do_store),
      .waddr(sel_q),
      .wdata(pend_q),
      .raddr_a(sel_q),
      .rdata_a(active_val),
      .raddr_b(set_rd_idx),
      .rdata_b(set_rd_val)
   );

   ////////////////////////////////////////////////////////////////////
   // records
   // a clear wins over a sample arriving in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         peak_q <= 16'h0000;
      end else if (do_peak) begin
         peak_q <= 16'h0000;
      end else if (temp_valid && temp_sample > peak_q) begin
         peak_q <= temp_sample;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stats_q <= 16'h0000;
      end else if (do_stats) begin
         stats_q <= 16'h0000;
      end else if (motor_start && stats_q != 16'hFFFF) begin
         stats_q <= stats_q + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         peak_clr <= 1'b0;
         stats_clr <= 1'b0;
      end else begin
         peak_clr <= do_peak;
         stats_clr <= do_stats;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flash message; a new action restarts the timer
   logic [31:0] flash_cnt_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         msg_q <= FPC_MSG_NONE;
         flash_cnt_q <= 32'h0000_0000;
      end else if (do_store) begin
         msg_q <= FPC_MSG_SAVED;
         flash_cnt_q <= FLASH_CYCLES;
      end else if (do_peak) begin
         msg_q <= FPC_MSG_PEAK;
         flash_cnt_q <= FLASH_CYCLES;
      end else if (do_stats) begin
         msg_q <= FPC_MSG_STATS;
         flash_cnt_q <= FLASH_CYCLES;
      end else if (flash_cnt_q > 32'h0000_0001) begin
         flash_cnt_q <= flash_cnt_q - 32'h0000_0001;
      end else begin
         flash_cnt_q <= 32'h0000_0000;
         msg_q <= FPC_MSG_NONE;
      end
   end
   assign flash_msg = msg_q;

   ////////////////////////////////////////////////////////////////////
   // lamps
   fpc_relays_t lamp_rel_q;
   logic svc_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         lamp_rel_q.trip <= 1'b0;
         lamp_rel_q.alarm <= 1'b0;
         lamp_rel_q.aux1 <= 1'b0;
         lamp_rel_q.aux2 <= 1'b0;
      end else begin
         lamp_rel_q.trip <= relays.trip;
         lamp_rel_q.alarm <= relays.alarm;
         lamp_rel_q.aux1 <= relays.aux1;
         lamp_rel_q.aux2 <= relays.aux2;
      end
   end
   assign lamps = {lamp_rel_q, svc_q};

   logic [31:0] blink_cnt_q, pwr_cnt_q;
   logic blink_q;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_q <= 1'b1;
      end else if (!selftest_fail) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_q <= 1'b1;
      end else if (blink_cnt_q >= SVC_HALF_CYCLES - 1) begin
         blink_cnt_q <= 32'h0000_0000;
         blink_q <= ~blink_q;
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pwr_cnt_q <= 32'h0000_0000;
      end else if (pwr_cnt_q < POWERUP_CYCLES) begin
         pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
      end
   end

   // failure outranks low supply, which outranks the power-up glow
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         svc_q <= 1'b0;
      end else if (selftest_fail) begin
         svc_q <= blink_q;
      end else begin
         svc_q <= supply_low || pwr_cnt_q < POWERUP_CYCLES;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_store_msg: assert property (@(posedge core_clk) disable iff (sys_rst)
      do_store |=> flash_msg == FPC_MSG_SAVED) else $error("no saved message after store");
   a_store_data: assert property (@(posedge core_clk) disable iff (sys_rst)
      do_store && !ack_q ##1 !do_store ##1 sel_q == $past(sel_q, 2) |-> active_val == $past(pend_q, 2))
      else $error("stored value not active");
   a_peak_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      do_peak |=> peak_q == 16'h0000 && peak_clr && flash_msg == FPC_MSG_PEAK) else $error("peak not cleared");
   a_stats_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      do_stats |=> stats_q == 16'h0000 && stats_clr && flash_msg == FPC_MSG_STATS)
      else $error("statistics not cleared");
   a_commit_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      !access_ok |-> !do_store && !do_peak && !do_stats) else $error("commit without jumper");
   a_commit_mode: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode inside {FPC_MODE_HELP, FPC_MODE_ALARM} |-> !do_store && !do_peak && !do_stats)
      else $error("commit acted in wrong mode");
   a_commit_once: assert property (@(posedge core_clk) disable iff (sys_rst)
      commit_edge |=> !commit_edge) else $error("commit repeated");
   a_lamp_trip: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 lamps.trip == $past(relays.trip) && lamps.alarm == $past(relays.alarm)) else $error("lamp mismatch");
   a_lamp_aux: assert property (@(posedge core_clk) disable iff (sys_rst)
      ##1 lamps.aux1 == $past(relays.aux1) && lamps.aux2 == $past(relays.aux2)) else $error("aux lamp mismatch");
   a_service_low: assert property (@(posedge core_clk) disable iff (sys_rst)
      !selftest_fail && supply_low ##1 !selftest_fail |-> lamps.service) else $error("service lamp not steady");
   a_service_blink: assert property (@(posedge core_clk) disable iff (sys_rst)
      selftest_fail [*2] |-> lamps.service == $past(blink_q)) else $error("service lamp not flashing");
   a_pend_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      act_ok_q && !$past(do_store) && $stable(sel_q) |=> $stable(active_val))
      else $error("pending leaked into store");
   a_answer_flip: assert property (@(posedge core_clk) disable iff (sys_rst)
      mode == FPC_MODE_ACTUAL && prompt && raise_edge && !(wr_en && wb_adr_i == ADR_CTRL) && !do_peak && !do_stats
      |=> answer_q != $past(answer_q)) else $error("answer did not toggle");

   c_store: cover property (@(posedge core_clk) disable iff (sys_rst) do_store);
   c_peak: cover property (@(posedge core_clk) disable iff (sys_rst) do_peak);
   c_stats: cover property (@(posedge core_clk) disable iff (sys_rst) do_stats);
   c_blink: cover property (@(posedge core_clk) disable iff (sys_rst) selftest_fail && $rose(blink_q));
endmodule
`default_nettype wire

// File: verilog/fpc_pkg.sv
// fpc_pkg: constants, types and register map of the front panel block
// assumes a 100 MHz core clock and a classic Wishbone register bus
package fpc_pkg;
   localparam int CLK_MHZ = 100;
   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_SEL = 8'h04;
   localparam logic [7:0] ADR_PEND = 8'h08;
   localparam logic [7:0] ADR_ACTIVE = 8'h0C;
   localparam logic [7:0] ADR_STATUS = 8'h10;
   localparam logic [7:0] ADR_PEAK = 8'h14;
   localparam logic [7:0] ADR_STATS = 8'h18;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PAGE_LSB = 2;
   localparam int CTRL_PROMPT_BIT = 5;
   localparam logic [2:0] PAGE_CLR_PEAK = 3'h2;
   localparam logic [2:0] PAGE_COMMISSION = 3'h4;
   // reset values and the pending value's upper limit
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [15:0] PEND_RST = 16'h0000;
   localparam logic [15:0] PEND_MAX = 16'hFFFF;
   // setting store shape
   localparam int SET_AW = 4;
   localparam int SET_DW = 16;
   // times and their cycle counts
   localparam int FLASH_MS = 2000;
   localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
   localparam int SVC_HALF_MS = 250;
   localparam int SVC_HALF_CYC = SVC_HALF_MS * 1000 * CLK_MHZ;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int POWERUP_MS = 1000;
   localparam int POWERUP_CYC = POWERUP_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {FPC_MODE_ACTUAL, FPC_MODE_SETPOINT, FPC_MODE_HELP, FPC_MODE_ALARM} fpc_mode_t;
   typedef enum logic [1:0] {FPC_MSG_NONE, FPC_MSG_SAVED, FPC_MSG_PEAK, FPC_MSG_STATS} fpc_msg_t;

   typedef struct packed {
      logic commit;
      logic raise;
      logic lower;
   } fpc_keys_t;

   typedef struct packed {
      logic trip;
      logic alarm;
      logic aux1;
      logic aux2;
   } fpc_relays_t;

   typedef struct packed {
      logic trip;
      logic alarm;
      logic aux1;
      logic aux2;
      logic service;
   } fpc_lamps_t;
endpackage

// File: verilog/fpc_in_filter.sv
// fpc_in_filter: synchroniser and debouncer for panel pins
// assumes raw inputs are asynchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module fpc_in_filter #(
   parameter int W = 1,
   parameter int unsigned CNT = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // pins and filtered levels
   input wire logic [W-1:0] raw,
   output logic [W-1:0] level,
   output logic [W-1:0] rise
);
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q, rise_q;
      logic [31:0] cnt_q;
      // s1 feeds s2 only
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
         end else begin
            s1_q <= raw[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
         end
      end
      // level must stay stable for CNT cycles before it is believed
      always_ff @(posedge core_clk) begin
         if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            lvl_q <= 1'b0;
            rise_q <= 1'b0;
         end else begin
            rise_q <= 1'b0;
            if (s2_q != s3_q || s3_q == lvl_q) begin
               cnt_q <= 32'h0000_0000;
            end else if (cnt_q >= CNT - 1) begin
               cnt_q <= 32'h0000_0000;
               lvl_q <= s3_q;
               rise_q <= s3_q;
            end else begin
               cnt_q <= cnt_q + 32'h0000_0001;
            end
         end
      end
      assign level[i] = lvl_q;
      assign rise[i] = rise_q;
   end
endmodule
`default_nettype wire

// File: verilog/fpc_set_mem.sv
// fpc_set_mem: active setting store, one write port, two registered reads
// assumes writes come only from the commit logic
`timescale 1ns/100ps
`default_nettype none
module fpc_set_mem
   import fpc_pkg::*;
(
   // clock
   input wire logic core_clk,
   // write port
   input wire logic we,
   input wire logic [SET_AW-1:0] waddr,
   input wire logic [SET_DW-1:0] wdata,
   // read ports
   input wire logic [SET_AW-1:0] raddr_a,
   output logic [SET_DW-1:0] rdata_a,
   input wire logic [SET_AW-1:0] raddr_b,
   output logic [SET_DW-1:0] rdata_b
);
   import fpc_pkg::*;
   logic [SET_DW-1:0] mem [0:(1<<SET_AW)-1];

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
   end
endmodule
`default_nettype wire

// File: sim/fpc_operator.sv
// fpc_operator: panel operator model, keypad keys and access jumper
// assumes the bench calls its tasks; pins change just after a core_clk edge
`timescale 1ns/100ps
`default_nettype none
module fpc_operator
   import fpc_pkg::*;
(
   // clock
   input wire logic core_clk,
   // panel pins
   output fpc_pkg::fpc_keys_t key_pin,
   output logic access_shorted
);
   import fpc_pkg::*;
   initial begin
      key_pin = '0;
      access_shorted = 1'b0;
   end
   // keys are plain switches: released means low, no bounce modelled
   task automatic hold(input logic [2:0] k);
      @(posedge core_clk);
      key_pin <= k;
   endtask
   // a press held well past the debounce time, then a release as long
   task automatic tap(input logic [2:0] k);
      hold(k);
      repeat (12) @(posedge core_clk);
      hold(3'h0);
      repeat (12) @(posedge core_clk);
   endtask
   task automatic jumper(input logic on);
      @(posedge core_clk);
      access_shorted <= on;
   endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// tb: self-checking bench of the front panel block
// assumes shortened counts: flash 50, service half 8, debounce 4, power-up 20
`timescale 1ns/100ps
`default_nettype none
module tb;
   import fpc_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, sel_v;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic wb_ack_o, access_shorted, selftest_fail, supply_low;
   logic temp_valid, motor_start, peak_clr, stats_clr;
   logic [15:0] temp_sample, set_rd_val;
   logic [3:0] set_rd_idx;
   fpc_keys_t key_pin;
   fpc_relays_t relays;
   fpc_lamps_t lamps;
   fpc_msg_t flash_msg;
   int error_cnt = 0, n_tests = 0, cyc_cnt = 0;
   always #5 core_clk = ~core_clk;
   fpc_operator op (.core_clk(core_clk), .key_pin(key_pin), .access_shorted(access_shorted));
   fpc_front_panel #(.FLASH_CYCLES(50), .SVC_HALF_CYCLES(8), .DEBOUNCE_CYCLES(4), .POWERUP_CYCLES(20)) dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .key_pin(key_pin), .access_shorted(access_shorted), .relays(relays), .selftest_fail(selftest_fail),
      .supply_low(supply_low), .temp_valid(temp_valid), .temp_sample(temp_sample), .motor_start(motor_start),
      .set_rd_idx(set_rd_idx), .set_rd_val(set_rd_val), .lamps(lamps), .flash_msg(flash_msg),
      .peak_clr(peak_clr), .stats_clr(stats_clr));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   // classic cycle: hold the request until ack is sampled, then release
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= sel_v;
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 100);
      if (n >= 100) chk(32'h0, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic settle();
      repeat (60) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      repeat (2) @(posedge core_clk);
      chk(lamps.service, 1'b1);
      chk(flash_msg, FPC_MSG_NONE);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      repeat (30) @(posedge core_clk);
      chk(lamps.service, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_lamps();
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         relays <= fpc_relays_t'(4'h8 >> i);
         repeat (3) @(posedge core_clk);
         chk(lamps.trip, i == 0);
         chk(lamps.alarm, i == 1);
         chk(lamps.aux1, i == 2);
         chk(lamps.aux2, i == 3);
      end
      relays <= '0;
      $display("test lamps done");
   endtask
   task automatic t_setpoint();
      op.jumper(1'b1);
      wb(1'b1, ADR_CTRL, 32'h01);
      wb(1'b1, ADR_SEL, 32'h3);
      wb(1'b1, ADR_PEND, 32'h1234);
      op.tap(3'b010);
      wb(1'b0, ADR_PEND, 32'h0);
      chk(rd, 32'h1235);
      set_rd_idx <= 4'h3;
      op.hold(3'b100);
      repeat (14) @(posedge core_clk);
      chk(set_rd_val, 16'h1235);
      chk(flash_msg, FPC_MSG_SAVED);
      wb(1'b0, ADR_ACTIVE, 32'h0);
      chk(rd, 32'h1235);
      wb(1'b1, ADR_PEND, 32'h0077);
      sel_v = 4'h2;
      wb(1'b1, ADR_PEND, 32'hAB00);
      sel_v = 4'hF;
      wb(1'b0, ADR_PEND, 32'h0);
      chk(rd, 32'hAB77);
      repeat (20) @(posedge core_clk);
      chk(set_rd_val, 16'h1235);
      op.hold(3'b000);
      settle();
      op.jumper(1'b0);
      op.tap(3'b100);
      chk(set_rd_val, 16'h1235);
      chk(flash_msg, FPC_MSG_NONE);
      $display("test setpoint done");
   endtask
   task automatic t_peak();
      @(posedge core_clk);
      temp_valid <= 1'b1;
      temp_sample <= 16'h0055;
      @(posedge core_clk);
      temp_valid <= 1'b0;
      wb(1'b0, ADR_PEAK, 32'h0);
      chk(rd, 32'h0055);
      op.jumper(1'b1);
      wb(1'b1, ADR_CTRL, 32'h28);
      op.tap(3'b001);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd[1], 1'b1);
      op.tap(3'b100);
      chk(flash_msg, FPC_MSG_PEAK);
      wb(1'b0, ADR_PEAK, 32'h0);
      chk(rd, 32'h0);
      settle();
      $display("test peak done");
   endtask
   task automatic t_stats();
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         motor_start <= 1'b1;
         @(posedge core_clk);
         motor_start <= 1'b0;
      end
      wb(1'b1, ADR_CTRL, 32'h32);
      op.tap(3'b100);
      wb(1'b0, ADR_STATS, 32'h0);
      chk(rd, 32'h3);
      chk(flash_msg, FPC_MSG_NONE);
      wb(1'b1, ADR_CTRL, 32'h30);
      op.tap(3'b010);
      op.tap(3'b100);
      chk(flash_msg, FPC_MSG_STATS);
      wb(1'b0, ADR_STATS, 32'h0);
      chk(rd, 32'h0);
      settle();
      $display("test stats done");
   endtask
   task automatic t_service();
      int tg, lit;
      logic prev;
      tg = 0;
      lit = 0;
      @(posedge core_clk);
      selftest_fail <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk(lamps.service, 1'b1);
      prev = lamps.service;
      repeat (32) begin
         @(posedge core_clk);
         if (lamps.service !== prev) tg++;
         prev = lamps.service;
      end
      chk(tg >= 3, 1'b1);
      selftest_fail <= 1'b0;
      supply_low <= 1'b1;
      repeat (2) @(posedge core_clk);
      repeat (20) begin
         @(posedge core_clk);
         if (lamps.service === 1'b1) lit++;
      end
      chk(lit, 20);
      supply_low <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(lamps.service, 1'b0);
      $display("test service done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      sel_v = 4'hF;
      wb_dat_i = 32'h0;
      selftest_fail = 1'b0;
      supply_low = 1'b0;
      temp_valid = 1'b0;
      motor_start = 1'b0;
      temp_sample = 16'h0000;
      set_rd_idx = 4'h0;
      relays = '0;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_reset();
      t_lamps();
      t_setpoint();
      t_peak();
      t_stats();
      t_service();
      close_out();
   end
endmodule
`default_nettype wire
